/* File: adcsr_ctrl.sv */
// Conversion timing and three-wire serial readout of a 12-bit converter
`timescale 1ns/100ps

module adcsr_ctrl #(
    parameter int RESULT_W = adcsr_pkg::RESULT_W,
    parameter int CONV_CYCLES = adcsr_pkg::CONV_CYCLES,
    parameter bit INT_REF = 1'b1
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Serial link pins
    input wire logic CS_N,
    input wire logic SCLK,
    output logic SERIAL_OUT,
    output logic SERIAL_OUT_OE_N,
    // Three-level power down pin, split into level and float sense
    input wire logic POWER_DOWN_N_LEVEL,
    input wire logic POWER_DOWN_N_FLOAT,
    // Sampled input in half-LSB units from the comparator front end
    input wire logic [RESULT_W:0] ANALOG_INPUT,
    // Converter control and status
    output logic TRACK_HOLD,
    output logic SHUTDOWN,
    output logic REF_ENABLE,
    output logic CONV_BUSY
);

    localparam int NPIN = adcsr_pkg::PIN_ANALOG + RESULT_W + 1;
    localparam logic [adcsr_pkg::CNT_W-1:0] CNT_LAST = adcsr_pkg::CNT_W'(CONV_CYCLES - 1);

    // ==========================================================
    // Declarations
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta;
    logic [NPIN-1:0] pin_sync;
    logic cs_n_prev;
    logic sclk_prev;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic pd_level;
    logic pd_float;
    logic shut_now;
    logic [RESULT_W:0] sample_half;
    logic [RESULT_W:0] sample_last;
    logic [RESULT_W:0] sample_steady;
    logic [RESULT_W+1:0] rounded;
    logic [RESULT_W-1:0] code;
    adcsr_pkg::adcsr_state_t state;
    adcsr_pkg::adcsr_state_t next_state;
    logic [adcsr_pkg::CNT_W-1:0] conv_cnt;
    logic conv_done;
    logic [RESULT_W-1:0] held_input;
    logic [RESULT_W-1:0] shift_reg;
    logic buf_in_valid;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;
    logic [RESULT_W-1:0] buf_out_data;
    logic buf_flush;

    // ==========================================================
    // Pin synchronisers, two flops per pin
    assign pin_raw = {ANALOG_INPUT, POWER_DOWN_N_FLOAT, POWER_DOWN_N_LEVEL, SCLK, CS_N};

    generate
        for (genvar i = 0; i < NPIN; i++) begin : g_sync
            localparam logic INIT = (i == adcsr_pkg::PIN_CS) ? 1'b1 : 1'b0;
            always_ff @(posedge CLK) begin
                if (RST) begin
                    pin_meta[i] <= INIT;
                    pin_sync[i] <= INIT;
                end else begin
                    pin_meta[i] <= pin_raw[i];
                    pin_sync[i] <= pin_meta[i];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Edge detection on synchronised pins
    always_ff @(posedge CLK) begin
        if (RST) begin
            cs_n_prev <= 1'b1;
            sclk_prev <= 1'b0;
        end else begin
            cs_n_prev <= pin_sync[adcsr_pkg::PIN_CS];
            sclk_prev <= pin_sync[adcsr_pkg::PIN_SCLK];
        end
    end

    assign cs_fall = cs_n_prev && !pin_sync[adcsr_pkg::PIN_CS];
    assign cs_rise = !cs_n_prev && pin_sync[adcsr_pkg::PIN_CS];
    assign sclk_fall = sclk_prev && !pin_sync[adcsr_pkg::PIN_SCLK];

    // ==========================================================
    // Power down decode
    assign pd_level = pin_sync[adcsr_pkg::PIN_PD_LEVEL];
    assign pd_float = pin_sync[adcsr_pkg::PIN_PD_FLOAT];
    assign shut_now = !pd_float && !pd_level;

    always_ff @(posedge CLK) begin
        if (RST) begin
            SHUTDOWN <= 1'b0;
        end else begin
            SHUTDOWN <= shut_now;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            REF_ENABLE <= 1'b0;
        end else begin
            REF_ENABLE <= INT_REF && !pd_float && pd_level;
        end
    end

    // ==========================================================
    // Word settling guard, the input bits cross one by one
    always_ff @(posedge CLK) begin
        if (RST) begin
            sample_last <= '0;
            sample_steady <= '0;
        end else begin
            sample_last <= pin_sync[NPIN-1:adcsr_pkg::PIN_ANALOG];
            if (pin_sync[NPIN-1:adcsr_pkg::PIN_ANALOG] == sample_last) begin
                sample_steady <= sample_last;
            end
        end
    end

    // ==========================================================
    // Straight binary quantiser, transitions at half LSB
    assign sample_half = sample_steady;
    assign rounded = {1'b0, sample_half} + (RESULT_W + 2)'(1);
    assign code = rounded[RESULT_W+1] ? {RESULT_W{1'b1}} : rounded[RESULT_W:1];

    // ==========================================================
    // Readout state machine
    always_comb begin
        next_state = state;
        unique case (state)
            adcsr_pkg::ST_IDLE: begin
                if (cs_fall && !shut_now) begin
                    next_state = adcsr_pkg::ST_CONV;
                end
            end
            adcsr_pkg::ST_CONV: begin
                if (cs_rise) begin
                    next_state = adcsr_pkg::ST_IDLE;
                end else if (conv_done && buf_in_ready) begin
                    next_state = adcsr_pkg::ST_LOAD;
                end
            end
            adcsr_pkg::ST_LOAD: begin
                if (cs_rise) begin
                    next_state = adcsr_pkg::ST_IDLE;
                end else if (buf_out_valid) begin
                    next_state = adcsr_pkg::ST_SHIFT;
                end
            end
            adcsr_pkg::ST_SHIFT: begin
                if (cs_rise) begin
                    next_state = adcsr_pkg::ST_IDLE;
                end
            end
        endcase
        if (shut_now) begin
            next_state = adcsr_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state <= adcsr_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Track and hold control
    always_ff @(posedge CLK) begin
        if (RST) begin
            TRACK_HOLD <= 1'b0;
            CONV_BUSY <= 1'b0;
        end else begin
            TRACK_HOLD <= (next_state == adcsr_pkg::ST_CONV);
            CONV_BUSY <= (next_state == adcsr_pkg::ST_CONV);
        end
    end

    // ==========================================================
    // Held sample, captured on the starting edge
    always_ff @(posedge CLK) begin
        if (RST) begin
            held_input <= adcsr_pkg::RESULT_RESET;
        end else if (state == adcsr_pkg::ST_IDLE && next_state == adcsr_pkg::ST_CONV) begin
            held_input <= code;
        end
    end

    // ==========================================================
    // Conversion timer in the local clock domain
    assign conv_done = (conv_cnt == CNT_LAST);

    always_ff @(posedge CLK) begin
        if (RST) begin
            conv_cnt <= adcsr_pkg::CNT_RESET;
        end else if (state != adcsr_pkg::ST_CONV) begin
            conv_cnt <= adcsr_pkg::CNT_RESET;
        end else if (!conv_done) begin
            conv_cnt <= conv_cnt + 1'b1;
        end
    end

    // ==========================================================
    // Result buffer between converter and shifter
    assign buf_in_valid = (state == adcsr_pkg::ST_CONV) && conv_done && !cs_rise && !shut_now;
    assign buf_out_ready = (state == adcsr_pkg::ST_LOAD) && !cs_rise && !shut_now;
    assign buf_flush = cs_rise || shut_now;

    adcsr_buf #(
        .WIDTH(RESULT_W),
        .DEPTH(adcsr_pkg::BUF_DEPTH)
    ) u_result_buf (
        .clk(CLK),
        .rst(RST),
        .flush(buf_flush),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(held_input),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    // ==========================================================
    // Result shift register
    always_ff @(posedge CLK) begin
        if (RST) begin
            shift_reg <= adcsr_pkg::RESULT_RESET;
        end else if (state == adcsr_pkg::ST_LOAD && next_state == adcsr_pkg::ST_SHIFT) begin
            shift_reg <= buf_out_data;
        end else if (state == adcsr_pkg::ST_SHIFT && sclk_fall) begin
            shift_reg <= {shift_reg[RESULT_W-2:0], 1'b0};
        end
    end

    // ==========================================================
    // Serial data pin enable, released whenever idle
    always_ff @(posedge CLK) begin
        if (RST) begin
            SERIAL_OUT_OE_N <= 1'b1;
        end else begin
            SERIAL_OUT_OE_N <= (next_state == adcsr_pkg::ST_IDLE);
        end
    end

    // ==========================================================
    // Serial data pin value
    always_ff @(posedge CLK) begin
        if (RST) begin
            SERIAL_OUT <= 1'b0;
        end else begin
            unique case (next_state)
                adcsr_pkg::ST_IDLE: begin
                    SERIAL_OUT <= 1'b0;
                end
                adcsr_pkg::ST_CONV, adcsr_pkg::ST_LOAD: begin
                    SERIAL_OUT <= 1'b0;
                end
                adcsr_pkg::ST_SHIFT: begin
                    if (state == adcsr_pkg::ST_LOAD) begin
                        SERIAL_OUT <= 1'b1;
                    end else if (sclk_fall) begin
                        SERIAL_OUT <= shift_reg[RESULT_W-1];
                    end
                end
            endcase
        end
    end

endmodule : adcsr_ctrl

/* File: adcsr_pkg.sv */
// Constants and types shared by the serial readout controller
package adcsr_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int CONV_TIME_NS = 8500;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    localparam int SCLK_MIN_PHASE_NS = 100;
    localparam int ACQ_MIN_NS = 1500;
    localparam int WAKE_TIME_NS = 2000;
    localparam int REF_CHARGE_MS = 20;

    // ==========================================================
    // Data widths and reset values
    localparam int RESULT_W = 12;
    localparam int SYNC_STAGES = 2;
    localparam int BUF_DEPTH = 2;
    localparam logic [11:0] CODE_MAX = 12'hFFF;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;

    // ==========================================================
    // Pin sampler layout
    localparam int PIN_CS = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_PD_LEVEL = 2;
    localparam int PIN_PD_FLOAT = 3;
    localparam int PIN_ANALOG = 4;
    localparam int PIN_COUNT = PIN_ANALOG + RESULT_W + 1;

    // ==========================================================
    // Readout states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CONV = 4'h2,
        ST_LOAD = 4'h4,
        ST_SHIFT = 4'h8
    } adcsr_state_t;

endpackage : adcsr_pkg

/* File: adcsr_buf.sv */
// Small result buffer with valid and ready on both sides
`timescale 1ns/100ps
module adcsr_buf #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] fill;
    logic push;
    logic pop;

    // ==========================================================
    // Handshake
    assign in_ready = (fill != CW'(DEPTH));
    assign out_valid = (fill != '0);
    assign out_data = store[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // ==========================================================
    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    // ==========================================================
    // Pointers and fill level
    always_ff @(posedge clk) begin
        if (rst || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                fill <= fill + 1'b1;
            end else if (pop && !push) begin
                fill <= fill - 1'b1;
            end
        end
    end

endmodule : adcsr_buf

/* File: adcsr_monitor.sv */
// Assertion checker for the serial readout controller
`timescale 1ns/100ps
module adcsr_monitor #(
    parameter int CONV_CYCLES = 2125
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Link pins
    input wire logic CS_N,
    input wire logic SCLK,
    input wire logic SERIAL_OUT,
    input wire logic SERIAL_OUT_OE_N,
    // Power pin and status
    input wire logic POWER_DOWN_N_LEVEL,
    input wire logic POWER_DOWN_N_FLOAT,
    input wire logic TRACK_HOLD,
    input wire logic SHUTDOWN,
    input wire logic REF_ENABLE,
    input wire logic CONV_BUSY
);
    int hold_len;
    int quiet;
    logic sclk_q;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // ==========================================================
    // Hold length and link quiet time
    always_ff @(posedge CLK) begin
        if (RST) begin
            hold_len <= 0;
        end else begin
            hold_len <= TRACK_HOLD ? hold_len + 1 : 0;
        end
    end
    always_ff @(posedge CLK) begin
        sclk_q <= SCLK;
        if (RST || SCLK != sclk_q || CS_N || TRACK_HOLD || SERIAL_OUT_OE_N) begin
            quiet <= 0;
        end else if (quiet < 9) begin
            quiet <= quiet + 1;
        end
    end

    // ==========================================================
    // Assertions
    AST_HOLD_START: assert property ($fell(CS_N) && SERIAL_OUT_OE_N && !SHUTDOWN |-> ##[2:5] TRACK_HOLD)
        else $error("conversion did not start after select fall");
    AST_BUSY: assert property (CONV_BUSY == TRACK_HOLD && (!$rose(CONV_BUSY) || $past(SERIAL_OUT_OE_N)))
        else $error("busy differs from hold or began while driving");
    AST_CONV_LOW: assert property (TRACK_HOLD |-> !SERIAL_OUT && !SERIAL_OUT_OE_N)
        else $error("output not driven low while converting");
    AST_CONV_LEN: assert property ($fell(TRACK_HOLD) |-> hold_len inside {[CONV_CYCLES:CONV_CYCLES+1]})
        else $error("conversion length wrong");
    AST_EOC: assert property ($fell(TRACK_HOLD) && !CS_N |-> ##[0:3] SERIAL_OUT)
        else $error("end of conversion not flagged");
    AST_QUIET: assert property (quiet > 6 |-> $stable(SERIAL_OUT))
        else $error("output changed without a serial clock edge");
    AST_RELEASE: assert property ($rose(CS_N) |-> ##[2:5] SERIAL_OUT_OE_N)
        else $error("output not released after select rise");
    AST_SHUT_ON: assert property ((!POWER_DOWN_N_LEVEL && !POWER_DOWN_N_FLOAT) [*5] |-> SHUTDOWN)
        else $error("shutdown not entered");
    AST_SHUT_OFF: assert property ((POWER_DOWN_N_LEVEL || POWER_DOWN_N_FLOAT) [*5] |-> !SHUTDOWN)
        else $error("shutdown while pin released");
    AST_SHUT_IDLE: assert property (SHUTDOWN |=> !TRACK_HOLD)
        else $error("converting in shutdown");
    AST_REF_ON: assert property ((POWER_DOWN_N_LEVEL && !POWER_DOWN_N_FLOAT) [*5] |-> REF_ENABLE)
        else $error("reference off with pin driven high");
    AST_REF_OFF: assert property (POWER_DOWN_N_FLOAT [*5] |-> !REF_ENABLE)
        else $error("reference on with pin floating");

    COV_EOC: cover property ($rose(SERIAL_OUT));
    COV_SHUT: cover property ($rose(SHUTDOWN));
    COV_START: cover property ($fell(CS_N) ##[2:5] TRACK_HOLD);
endmodule : adcsr_monitor

bind adcsr_ctrl adcsr_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_adcsr_monitor (
    .CLK(CLK), .RST(RST), .CS_N(CS_N), .SCLK(SCLK), .SERIAL_OUT(SERIAL_OUT),
    .SERIAL_OUT_OE_N(SERIAL_OUT_OE_N), .POWER_DOWN_N_LEVEL(POWER_DOWN_N_LEVEL),
    .POWER_DOWN_N_FLOAT(POWER_DOWN_N_FLOAT), .TRACK_HOLD(TRACK_HOLD), .SHUTDOWN(SHUTDOWN),
    .REF_ENABLE(REF_ENABLE), .CONV_BUSY(CONV_BUSY)
);

/* File: adcsr_host.sv */
// Serial master model that starts conversions and clocks out results
`timescale 1ns/100ps
module adcsr_host (
    // Clock
    input wire logic clk,
    // Link pins
    output logic cs_n,
    output logic sclk,
    input wire logic dout,
    input wire logic dout_oe_n,
    // Received frame
    output logic [15:0] rx_word,
    output logic rx_done,
    output logic timed_out
);
    logic last;
    logic line;

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        rx_word = 16'h0000;
        rx_done = 1'b0;
        timed_out = 1'b0;
        last = 1'b0;
    end

    // Released pin shows the inverse of its last driven value
    always @(negedge clk) begin
        if (!dout_oe_n) begin
            last <= dout;
        end
    end
    assign line = dout_oe_n ? ~last : dout;

    // ==========================================================
    // One conversion and a readout of nfall bits, optionally late
    task frame(input int nfall, input int stall);
        int i;
        rx_word = 16'h0000;
        @(negedge clk);
        cs_n = 1'b0;
        i = 0;
        while (line !== 1'b0 && i < 4000) begin
            @(negedge clk);
            i++;
        end
        while (line !== 1'b1 && i < 4000) begin
            @(negedge clk);
            i++;
        end
        if (i == 4000) begin
            timed_out = 1'b1;
        end
        repeat (stall) @(negedge clk);
        for (i = 0; i < nfall; i++) begin
            repeat (8) @(negedge clk);
            sclk = 1'b1;
            rx_word = {rx_word[14:0], line};
            repeat (8) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (8) @(negedge clk);
        cs_n = 1'b1;
        rx_done = 1'b1;
        @(negedge clk);
        rx_done = 1'b0;
        repeat (400) @(negedge clk);
    endtask : frame

    // Select driven to a level with the serial clock idle
    task hold_select(input logic level);
        @(negedge clk);
        cs_n = level;
    endtask : hold_select
endmodule : adcsr_host

/* File: adcsr_tb.sv */
// Self-checking bench for the serial readout controller
`timescale 1ns/100ps
module tb;
    localparam int CC = 20;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic pd_level = 1'b1;
    logic pd_float = 1'b0;
    logic [12:0] analog = 13'h0000;
    logic cs_n, sclk, serial_out, oe_n, track_hold, shutdown, ref_en, busy, rx_done, timed_out;
    logic [15:0] rx_word;
    logic [15:0] expq[$];
    logic [12:0] tv[6] = '{13'h0000, 13'h0001, 13'h0002, 13'h1FFD, 13'h1FFE, 13'h1FFF};
    int mismatches = 0;
    int n_tests = 0;
    int seed = 32'h966B;
    int i;

    adcsr_ctrl #(.CONV_CYCLES(CC)) u_adcsr_ctrl (
        .CLK(CLK), .RST(RST), .CS_N(cs_n), .SCLK(sclk), .SERIAL_OUT(serial_out), .SERIAL_OUT_OE_N(oe_n),
        .POWER_DOWN_N_LEVEL(pd_level), .POWER_DOWN_N_FLOAT(pd_float), .ANALOG_INPUT(analog),
        .TRACK_HOLD(track_hold), .SHUTDOWN(shutdown), .REF_ENABLE(ref_en), .CONV_BUSY(busy)
    );
    adcsr_host u_adcsr_host (
        .clk(CLK), .cs_n(cs_n), .sclk(sclk), .dout(serial_out), .dout_oe_n(oe_n),
        .rx_word(rx_word), .rx_done(rx_done), .timed_out(timed_out)
    );

    // ==========================================================
    // Reporting and comparison
    task wrap_up;
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    task cmp_word(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : cmp_word
    task cmp_flags(input logic [1:0] got, input logic [1:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: flags %h expected %h", $time, got, exp);
        end
    endtask : cmp_flags
    function automatic logic [11:0] code_of(input logic [12:0] a);
        logic [13:0] t;
        t = {1'b0, a} + 14'h0001;
        return (t[13:1] > 13'h0FFF) ? 12'hFFF : t[12:1];
    endfunction : code_of
    task run(input logic [12:0] a, input int nfall, input int stall);
        logic [15:0] full;
        analog = a;
        full = {1'b1, code_of(a), 3'b000};
        expq.push_back(full >> (16 - nfall));
        repeat (4) @(negedge CLK);
        u_adcsr_host.frame(nfall, stall);
        if (timed_out === 1'b1) begin
            mismatches++;
            wrap_up;
        end
    endtask : run

    // ==========================================================
    // Result watcher
    always @(posedge CLK) begin
        if (rx_done === 1'b1) begin
            cmp_word(rx_word, expq.size() > 0 ? expq.pop_front() : 16'hXXXX);
        end
    end

    // ==========================================================
    // Clock, watchdog and main sequence
    initial begin
        forever #2 CLK = ~CLK;
    end
    initial begin
        repeat (100000) @(posedge CLK);
        mismatches++;
        wrap_up;
    end
    initial begin
        repeat (4) @(negedge CLK);
        RST = 1'b0;
        repeat (8) @(negedge CLK);
        for (i = 0; i < 6; i++) begin
            run(tv[i], 16, 0);
        end
        for (i = 0; i < 8; i++) begin
            pd_float = 1'($random(seed));
            pd_level = pd_float ? 1'($random(seed)) : 1'b1;
            repeat (6) @(negedge CLK);
            cmp_flags({shutdown, ref_en}, {1'b0, ~pd_float});
            run(13'($random(seed)), 13 + i % 4, i * 300);
        end
        run(13'h0AAA, 5, 0);
        cmp_flags({oe_n, serial_out}, 2'b10);
        run(13'h1555, 16, 0);
        pd_level = 1'b0;
        pd_float = 1'b0;
        repeat (6) @(negedge CLK);
        cmp_flags({shutdown, ref_en}, 2'b10);
        u_adcsr_host.hold_select(1'b0);
        repeat (CC + 20) @(negedge CLK);
        cmp_flags({oe_n, track_hold}, 2'b10);
        u_adcsr_host.hold_select(1'b1);
        pd_level = 1'b1;
        repeat (500) @(negedge CLK);
        cmp_flags({shutdown, ref_en}, 2'b01);
        run(13'h0800, 16, 0);
        wrap_up;
    end
endmodule : tb
